// ==== tir_map.svh ====
// register map, field widths, reset values and timing counts of the integration and readout controller
// included by the controller, the monitor and the bench; definitions only
`ifndef TIR_MAP_SVH
`define TIR_MAP_SVH

`define TIR_ADR_CTRL 8'h00
`define TIR_ADR_RATIO 8'h04
`define TIR_ADR_SCALE 8'h08
`define TIR_ADR_PERIOD 8'h0c
`define TIR_ADR_SUBF 8'h10
`define TIR_ADR_ROWS 8'h14
`define TIR_ADR_COLS 8'h18
`define TIR_ADR_PHASE 8'h1c
`define TIR_ADR_STATUS 8'h20

`define TIR_CTRL_RUN 0
`define TIR_CTRL_ALT 1
`define TIR_CTRL_SLAVE 2
`define TIR_CTRL_VMIR 3
`define TIR_CTRL_CMIR 4
`define TIR_CTRL_SHUT 5
`define TIR_CTRL_HOP 6
`define TIR_CTRL_LUMP 7

`define TIR_RST_RATIO 6'h0d
`define TIR_RST_SCALE 6'h3f
`define TIR_RST_PERIOD 16'h30d4
`define TIR_RST_SUBF1 8'h10
`define TIR_RST_SUBF2 8'h04
`define TIR_RST_ROW_END 7'h3b
`define TIR_RST_COL_END 7'h4f
`define TIR_RST_PHASE 8'he4

`define TIR_RESET_CLKS 16'h02d0
`define TIR_PREP_CLKS 16'h0064
`define TIR_TOTAL_COLS 8'h50
`define TIR_HALF_COLS 8'h28
`define TIR_QUADS 2'h3
`define TIR_RATIO_MIN 6'h01
`define TIR_RATIO_SHIFT 6

`endif

// ==== tir_pkg.sv ====
// types shared by the integration and readout controller
// uses no macro from tir_map.svh and includes nothing
package tir_pkg;
	typedef enum logic [1:0]
	{
		TIR_Q_RESET = 2'b00,
		TIR_Q_INTEG = 2'b01,
		TIR_Q_READ = 2'b11,
		TIR_Q_DEAD = 2'b10
	} tir_quad_t;
endpackage

// ==== tir_ctrl.sv ====
// integration length, readout window, shutter and phase stepping of one quad sequencer
// assumes a classic wishbone master on the 20 MHz system clock and a synchronous sync pulse
// Operation
// R1 - modulation active only during integration
// R2 - ratio setting takes values 0 to 63
// R3 - integration share is setting over 64
// R4 - zero setting acts as one
// R5 - flag set when ratio does not fit
// R6 - flag cleared when fitting ratio written
// R7 - host lowers ratio until flag clears
// R8 - host rewrites ratio after timing changes
// R9 - slave integration from internal frame length
// R10 - sync pulses spaced past frame output
// R11 - supplementary ratio scaled by scale+1 over 64
// R12 - read only rows and columns in bounds
// R13 - row switch no shorter than half row
// R14 - readout 100 plus rows times columns
// R15 - vertical mirror reverses row order
// R16 - column mirror reverses column order
// R17 - phase steps with quad number
// R18 - programmable order, alternate for odd subframes
// R19 - separate phase order per modulation frequency
// R20 - shutter on in reset and integration only; the code also holds it on while no frame is running
// R21 - shutter disabled keeps switch always on
// R22 - writing one enables shutter operation
// R23 - 720 clocks of sensor reset per quad
// R24 - hop adds offset to quad number
// R25 - quad runs reset, integration, readout, dead
`timescale 1ns/1ps
`include "tir_map.svh"

module tir_ctrl
	import tir_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	input wire logic [3:0] wb_sel_in,
	input wire logic wb_we_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	output logic wb_ack_out,
	input wire logic external_frame_sync_input,
	output logic modulation_active_out,
	output logic shutter_on_out,
	output logic [1:0] phase_step_out,
	output logic supplementary_frame_out,
	output logic pixel_valid_out,
	output logic [6:0] pixel_row_out,
	output logic [6:0] pixel_col_out,
	output logic frame_start_out
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_r;
	logic [5:0] integration_ratio_setting_r;
	logic [5:0] supplementary_integration_scale_r;
	logic [15:0] quad_period_clocks_r;
	logic [7:0] base_subframe_total_r;
	logic [7:0] supplementary_subframe_total_r;
	logic [6:0] row_start_r;
	logic [6:0] row_end_r;
	logic [6:0] col_start_r;
	logic [6:0] col_end_r;
	logic [7:0] phase_base_r;
	logic [7:0] phase_supp_r;
	logic [1:0] quad_hop_offset_r;
	logic integration_infeasible_flag_r;
	logic ack_r;
	logic [31:0] rdata_r;

	logic wr_req;
	logic ratio_wr;
	assign wr_req = wb_cyc_in && wb_stb_in && wb_we_in && ack_r;
	assign ratio_wr = wr_req && wb_adr_in == `TIR_ADR_RATIO && wb_sel_in[0];
	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdata_r;

	// one wait state; ack drops in the cycle after it was given
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			ack_r <= 1'b0;
		else
			ack_r <= wb_cyc_in && wb_stb_in && !ack_r;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ctrl_r <= 8'h00;
			integration_ratio_setting_r <= `TIR_RST_RATIO;
			supplementary_integration_scale_r <= `TIR_RST_SCALE;
			quad_period_clocks_r <= `TIR_RST_PERIOD;
			base_subframe_total_r <= `TIR_RST_SUBF1;
			supplementary_subframe_total_r <= `TIR_RST_SUBF2;
			row_start_r <= 7'h00;
			row_end_r <= `TIR_RST_ROW_END;
			col_start_r <= 7'h00;
			col_end_r <= `TIR_RST_COL_END;
			phase_base_r <= `TIR_RST_PHASE;
			phase_supp_r <= `TIR_RST_PHASE;
			quad_hop_offset_r <= 2'h0;
		end
		else if (wr_req)
		begin
			unique case (wb_adr_in)
				`TIR_ADR_CTRL:
					if (wb_sel_in[0]) ctrl_r <= wb_dat_in[7:0]; // R22
				`TIR_ADR_RATIO:
					if (wb_sel_in[0]) integration_ratio_setting_r <= wb_dat_in[5:0]; // R2
				`TIR_ADR_SCALE:
					if (wb_sel_in[0]) supplementary_integration_scale_r <= wb_dat_in[5:0];
				`TIR_ADR_PERIOD:
				begin
					if (wb_sel_in[0]) quad_period_clocks_r[7:0] <= wb_dat_in[7:0];
					if (wb_sel_in[1]) quad_period_clocks_r[15:8] <= wb_dat_in[15:8];
				end
				`TIR_ADR_SUBF:
				begin
					if (wb_sel_in[0]) base_subframe_total_r <= wb_dat_in[7:0];
					if (wb_sel_in[1]) supplementary_subframe_total_r <= wb_dat_in[15:8];
				end
				`TIR_ADR_ROWS:
				begin
					if (wb_sel_in[0]) row_start_r <= wb_dat_in[6:0];
					if (wb_sel_in[1]) row_end_r <= wb_dat_in[14:8];
				end
				`TIR_ADR_COLS:
				begin
					if (wb_sel_in[0]) col_start_r <= wb_dat_in[6:0];
					if (wb_sel_in[1]) col_end_r <= wb_dat_in[14:8];
				end
				`TIR_ADR_PHASE:
				begin
					if (wb_sel_in[0]) phase_base_r <= wb_dat_in[7:0]; // R19
					if (wb_sel_in[1]) phase_supp_r <= wb_dat_in[15:8]; // R19
					if (wb_sel_in[2]) quad_hop_offset_r <= wb_dat_in[17:16];
				end
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timing arithmetic
	logic [6:0] rows_span;
	logic [7:0] cols_span;
	logic [7:0] cols_eff;
	logic [15:0] readout_clks;
	logic [15:0] overhead_clks;
	logic [21:0] base_product;
	logic [15:0] base_integ_clks;
	logic [21:0] supp_product;
	logic [15:0] supp_integ_clks;
	logic [15:0] integ_clks;
	logic [5:0] ratio_eff;
	logic [5:0] wr_ratio_eff;
	logic [21:0] wr_product;
	logic wr_fits;

	assign rows_span = row_end_r - row_start_r; // R12
	assign cols_span = {1'b0, col_end_r - col_start_r}; // R12
	// narrow windows still pay half a row per row switch
	assign cols_eff = (cols_span + 8'h01 < `TIR_HALF_COLS) ? `TIR_HALF_COLS : cols_span + 8'h01; // R13
	assign readout_clks = `TIR_PREP_CLKS + 16'({9'h000, rows_span} + 16'h0001) * 16'(cols_eff); // R14
	assign overhead_clks = `TIR_RESET_CLKS + readout_clks;

	assign ratio_eff = (integration_ratio_setting_r < `TIR_RATIO_MIN) ? `TIR_RATIO_MIN
		: integration_ratio_setting_r; // R4
	// integration comes from the programmed period even when slaved to an external sync
	assign base_product = quad_period_clocks_r * ratio_eff; // R3 R9
	assign base_integ_clks = base_product[21:`TIR_RATIO_SHIFT]; // R3
	assign supp_product = base_integ_clks * ({1'b0, supplementary_integration_scale_r} + 7'h01); // R11
	assign supp_integ_clks = supp_product[21:`TIR_RATIO_SHIFT]; // R11

	assign wr_ratio_eff = (wb_dat_in[5:0] < `TIR_RATIO_MIN) ? `TIR_RATIO_MIN : wb_dat_in[5:0];
	assign wr_product = quad_period_clocks_r * wr_ratio_eff;
	assign wr_fits = {6'h00, overhead_clks} + wr_product[21:`TIR_RATIO_SHIFT] <= {6'h00, quad_period_clocks_r};

	// judged only at the ratio write; other timing writes need a ratio rewrite
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			integration_infeasible_flag_r <= 1'b0;
		else if (ratio_wr)
			integration_infeasible_flag_r <= !wr_fits; // R5 R6 R8
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			rdata_r <= 32'h00000000;
		else if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack_r)
		begin
			unique case (wb_adr_in)
				`TIR_ADR_CTRL: rdata_r <= {24'h000000, ctrl_r};
				`TIR_ADR_RATIO: rdata_r <= {26'h0000000, integration_ratio_setting_r};
				`TIR_ADR_SCALE: rdata_r <= {26'h0000000, supplementary_integration_scale_r};
				`TIR_ADR_PERIOD: rdata_r <= {16'h0000, quad_period_clocks_r};
				`TIR_ADR_SUBF: rdata_r <= {16'h0000, supplementary_subframe_total_r, base_subframe_total_r};
				`TIR_ADR_ROWS: rdata_r <= {17'h00000, row_end_r, 1'b0, row_start_r};
				`TIR_ADR_COLS: rdata_r <= {17'h00000, col_end_r, 1'b0, col_start_r};
				`TIR_ADR_PHASE: rdata_r <= {14'h0000, quad_hop_offset_r, phase_supp_r, phase_base_r};
				`TIR_ADR_STATUS: rdata_r <= {15'h0000, supplementary_frame_out, readout_clks}
					| {31'h00000000, integration_infeasible_flag_r} << 31;
				default: rdata_r <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// quad sequencer
	tir_quad_t state_r;
	logic [15:0] clk_cnt_r;
	logic [1:0] quad_r;
	logic [7:0] subframe_r;
	logic supp_r;
	logic running_r;
	logic [6:0] row_cnt_r;
	logic [7:0] col_cnt_r;
	logic [6:0] prep_cnt_r;
	logic sync_d_r;

	logic run_en;
	logic slave_en;
	logic sync_rise;
	logic frame_go;
	logic last_quad;
	logic [7:0] sub_total;
	logic [15:0] state_len;
	logic state_done;

	assign run_en = ctrl_r[`TIR_CTRL_RUN];
	assign slave_en = ctrl_r[`TIR_CTRL_SLAVE];
	assign sync_rise = external_frame_sync_input && !sync_d_r;
	// in slave mode a sync mid-frame is ignored
	assign frame_go = run_en && !running_r && (!slave_en || sync_rise); // R10
	assign integ_clks = supp_r ? supp_integ_clks : base_integ_clks;
	assign sub_total = supp_r ? supplementary_subframe_total_r : base_subframe_total_r;
	assign last_quad = quad_r == `TIR_QUADS && subframe_r + 8'h01 >= sub_total;

	always_comb
	begin
		unique case (state_r)
			TIR_Q_RESET: state_len = `TIR_RESET_CLKS; // R23
			TIR_Q_INTEG: state_len = integ_clks;
			TIR_Q_READ: state_len = readout_clks;
			TIR_Q_DEAD: state_len = quad_period_clocks_r - `TIR_RESET_CLKS - integ_clks - readout_clks;
		endcase
	end
	// an infeasible dead time wraps, so the dead state is cut to one clock
	assign state_done = clk_cnt_r + 16'h0001 >= state_len || (state_r == TIR_Q_DEAD
		&& quad_period_clocks_r < overhead_clks + integ_clks);

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			sync_d_r <= 1'b0;
		else
			sync_d_r <= external_frame_sync_input;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_r <= TIR_Q_RESET;
			clk_cnt_r <= 16'h0000;
			quad_r <= 2'h0;
			subframe_r <= 8'h00;
			supp_r <= 1'b0;
			running_r <= 1'b0;
		end
		else if (!running_r)
		begin
			state_r <= TIR_Q_RESET;
			clk_cnt_r <= 16'h0000;
			quad_r <= 2'h0;
			subframe_r <= 8'h00;
			running_r <= frame_go;
		end
		else if (state_done)
		begin
			clk_cnt_r <= 16'h0000;
			unique case (state_r) // R25
				TIR_Q_RESET: state_r <= TIR_Q_INTEG;
				TIR_Q_INTEG: state_r <= TIR_Q_READ;
				TIR_Q_READ: state_r <= TIR_Q_DEAD;
				TIR_Q_DEAD:
				begin
					state_r <= TIR_Q_RESET;
					quad_r <= quad_r + 2'h1; // R17
					if (quad_r == `TIR_QUADS)
						subframe_r <= subframe_r + 8'h01;
					if (last_quad)
					begin
						running_r <= 1'b0;
						supp_r <= ctrl_r[`TIR_CTRL_ALT] && !supp_r; // R11
					end
				end
			endcase
		end
		else
			clk_cnt_r <= clk_cnt_r + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	// readout scan
	logic [6:0] col_lo_end;
	assign col_lo_end = cols_eff[6:0] - 7'h01;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			prep_cnt_r <= 7'h00;
			row_cnt_r <= 7'h00;
			col_cnt_r <= 8'h00;
			pixel_valid_out <= 1'b0;
			pixel_row_out <= 7'h00;
			pixel_col_out <= 7'h00;
		end
		else if (running_r && state_r == TIR_Q_READ)
		begin
			if (prep_cnt_r < `TIR_PREP_CLKS)
			begin
				prep_cnt_r <= prep_cnt_r + 7'h01;
				pixel_valid_out <= 1'b0;
			end
			else
			begin
				// slots past the column window keep the half-row minimum
				pixel_valid_out <= col_cnt_r <= cols_span;
				pixel_row_out <= ctrl_r[`TIR_CTRL_VMIR] ? row_end_r - row_cnt_r : row_start_r + row_cnt_r; // R15
				pixel_col_out <= ctrl_r[`TIR_CTRL_CMIR] ? col_end_r - col_cnt_r[6:0]
					: col_start_r + col_cnt_r[6:0]; // R16
				if (col_cnt_r[6:0] >= col_lo_end)
				begin
					col_cnt_r <= 8'h00;
					row_cnt_r <= row_cnt_r + 7'h01;
				end
				else
					col_cnt_r <= col_cnt_r + 8'h01;
			end
		end
		else
		begin
			prep_cnt_r <= 7'h00;
			row_cnt_r <= 7'h00;
			col_cnt_r <= 8'h00;
			pixel_valid_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// modulation, shutter and phase outputs
	logic [1:0] quad_eff;
	logic [7:0] phase_sel;
	assign quad_eff = (ctrl_r[`TIR_CTRL_HOP] && subframe_r[0]) ? quad_r + quad_hop_offset_r : quad_r; // R18 R24
	assign phase_sel = supp_r ? phase_supp_r : phase_base_r; // R19

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			modulation_active_out <= 1'b0;
			shutter_on_out <= 1'b1;
			phase_step_out <= 2'h0;
			supplementary_frame_out <= 1'b0;
			frame_start_out <= 1'b0;
		end
		else
		begin
			modulation_active_out <= running_r && state_r == TIR_Q_INTEG; // R1
			// closed shutter keeps ambient charge out of the storage node
			shutter_on_out <= !ctrl_r[`TIR_CTRL_SHUT] || !running_r
				|| state_r == TIR_Q_RESET || state_r == TIR_Q_INTEG; // R20 R21
			phase_step_out <= phase_sel[{quad_eff, 1'b0} +: 2]; // R17 R18
			supplementary_frame_out <= supp_r;
			frame_start_out <= frame_go;
		end
	end

endmodule

// ==== tir_ctrl_monitor.sv ====
// port assertions of the integration and readout controller
// assumes bus writes use all byte lanes; config is snooped from them
`timescale 1ns/1ps
`include "tir_map.svh"
module tir_ctrl_monitor
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_we_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic external_frame_sync_input,
	input wire logic modulation_active_out,
	input wire logic shutter_on_out,
	input wire logic [1:0] phase_step_out,
	input wire logic supplementary_frame_out,
	input wire logic pixel_valid_out,
	input wire logic [6:0] pixel_row_out,
	input wire logic [6:0] pixel_col_out,
	input wire logic frame_start_out
);
	logic [7:0] ctl_r;
	logic [5:0] rat_r;
	logic [15:0] per_r;
	logic [14:0] row_r;
	logic [14:0] col_r;
	logic [15:0] hi_r;
	logic [5:0] rat_w;
	logic [21:0] int_w;
	wire wr_w = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
	assign rat_w = (rat_r == 6'h00) ? 6'h01 : rat_r;
	assign int_w = (per_r * rat_w) >> 6;
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ctl_r <= 8'h00;
			rat_r <= `TIR_RST_RATIO;
			per_r <= `TIR_RST_PERIOD;
			row_r <= {`TIR_RST_ROW_END, 8'h00};
			col_r <= {`TIR_RST_COL_END, 8'h00};
		end
		else if (wr_w)
		begin
			if (wb_adr_in == `TIR_ADR_CTRL) ctl_r <= wb_dat_in[7:0];
			if (wb_adr_in == `TIR_ADR_RATIO) rat_r <= wb_dat_in[5:0];
			if (wb_adr_in == `TIR_ADR_PERIOD) per_r <= wb_dat_in[15:0];
			if (wb_adr_in == `TIR_ADR_ROWS) row_r <= wb_dat_in[14:0];
			if (wb_adr_in == `TIR_ADR_COLS) col_r <= wb_dat_in[14:0];
		end
	end
	// length of the current integration run
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || !modulation_active_out)
			hi_r <= 16'h0000;
		else
			hi_r <= hi_r + 16'h0001;
	end
	////////////////////////////////////////////////////////////////
	default clocking mcb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
	ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack missing");
	fs_pulse_a: assert property (frame_start_out |=> !frame_start_out) else $error("frame start too long");
	integ_shutter_a: assert property (modulation_active_out |-> shutter_on_out) else $error("shutter off");
	reset_time_a: assert property (
		frame_start_out |-> ##[715:725] $rose(modulation_active_out)) else $error("reset time wrong");
	phase_hold_a: assert property (
		modulation_active_out && $past(modulation_active_out) |-> $stable(phase_step_out)) else $error("phase moved");
	pix_window_a: assert property (
		pixel_valid_out |-> pixel_row_out >= row_r[6:0] && pixel_row_out <= row_r[14:8]
		&& pixel_col_out >= col_r[6:0] && pixel_col_out <= col_r[14:8]) else $error("pixel outside window");
	pix_integ_a: assert property (pixel_valid_out |-> !modulation_active_out) else $error("read in integ");
	pix_shutter_a: assert property (
		pixel_valid_out |-> shutter_on_out == !ctl_r[`TIR_CTRL_SHUT]) else $error("shutter in readout wrong");
	integ_len_a: assert property (
		$fell(modulation_active_out) && !supplementary_frame_out |-> {6'h00, hi_r} == int_w)
		else $error("integration length wrong");
	slave_start_a: assert property (
		frame_start_out && ctl_r[`TIR_CTRL_SLAVE] |-> $past(external_frame_sync_input)
		&& !$past(external_frame_sync_input, 2)) else $error("slave start without sync");
endmodule
bind tir_ctrl tir_ctrl_monitor i_mon (.sys_clk_in, .rst_in, .wb_adr_in, .wb_dat_in, .wb_we_in, .wb_cyc_in,
	.wb_stb_in, .wb_ack_out, .external_frame_sync_input, .modulation_active_out, .shutter_on_out,
	.phase_step_out, .supplementary_frame_out, .pixel_valid_out, .pixel_row_out, .pixel_col_out, .frame_start_out);

// ==== tir_sync_src.sv ====
// external frame sync source for slave mode
// the bench requests one pulse to start a frame and one more mid-frame
`timescale 1ns/1ps
module tir_sync_src
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	output logic sync_out
);
	logic [1:0] cnt_r;
	// two clocks wide so the edge is seen reliably
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			cnt_r <= 2'h0;
		else if (req_in)
			cnt_r <= 2'h2;
		else if (cnt_r != 2'h0)
			cnt_r <= cnt_r - 2'h1;
	end
	assign sync_out = (cnt_r != 2'h0);
endmodule

// ==== tir_ctrl_bench.sv ====
// self-checking bench of the integration and readout controller
// assumes the bound monitor and the sync source model
`timescale 1ns/1ps
`include "tir_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tir_ctrl_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic req = 1'b0;
	logic sync, ack, mod, shut, supp, pv, fso, mod_d, sh_q, sp_q;
	logic [31:0] dat;
	logic [1:0] phase, ph;
	logic [6:0] row, col, fr, fc;
	logic [15:0] cur_len;
	int pix_n = 0;
	int fs_n = 0;
	int bad_count = 0;
	int compares = 0;
	localparam logic [7:0] TA [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h40};
	localparam logic [31:0] TE [9] = '{32'h0, 32'hd, 32'h3f, 32'h30d4, 32'h0410, 32'h3b00, 32'h4f00, 32'he4e4, 32'h0};
	always #25 clk = ~clk;
	tir_ctrl i_dut (.sys_clk_in(clk), .rst_in(rst), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_dat_out(dat),
		.wb_sel_in(4'hf), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_ack_out(ack),
		.external_frame_sync_input(sync), .modulation_active_out(mod), .shutter_on_out(shut),
		.phase_step_out(phase), .supplementary_frame_out(supp), .pixel_valid_out(pv),
		.pixel_row_out(row), .pixel_col_out(col), .frame_start_out(fso));
	tir_sync_src i_sync (.sys_clk_in(clk), .rst_in(rst), .req_in(req), .sync_out(sync));
	////////////////////////////////////////////////////////////////
	// per-quad capture; values stay intact until the next rise lands
	always @(posedge clk)
	begin
		mod_d <= mod;
		if (fso === 1'b1) fs_n <= fs_n + 1;
		if (mod === 1'b1 && mod_d !== 1'b1)
		begin
			cur_len <= 16'h1;
			pix_n <= 0;
			ph <= phase;
			sp_q <= supp;
		end
		else if (mod === 1'b1)
			cur_len <= cur_len + 16'h1;
		if (pv === 1'b1)
		begin
			pix_n <= pix_n + 1;
			sh_q <= shut;
			if (pix_n == 0) fr <= row;
			if (pix_n == 0) fc <= col;
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk);
		while (ack !== 1'b1)
		begin
			n++;
			if (n > 20) begin bad_count++; results(); end
			@(posedge clk);
		end
		rdat = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK("read", e, rdat)
	endtask
	task automatic edge_wait();
		int n;
		n = 0;
		@(posedge clk);
		while (!(mod === 1'b1 && mod_d === 1'b0))
		begin
			n++;
			if (n > 3000) begin bad_count++; results(); end
			@(posedge clk);
		end
	endtask
	// waits for the next quad, then judges the one just finished
	task automatic q(input logic [15:0] len, input logic [1:0] p, input logic [6:0] r, input logic [6:0] c,
		input logic sh, input logic sp);
		edge_wait();
		`CHK("len", len, cur_len)
		`CHK("pixels", 8, pix_n)
		`CHK("phase", p, ph)
		`CHK("row", r, fr)
		`CHK("col", c, fc)
		`CHK("shutter", sh, sh_q)
		`CHK("supp", sp, sp_q)
	endtask
	// small window and short period keep one quad at 1200 clocks
	task automatic cfg(input logic [7:0] ctl, input logic [5:0] ratio);
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wr(`TIR_ADR_PERIOD, 32'h4b0);
		wr(`TIR_ADR_SUBF, 32'h0101);
		wr(`TIR_ADR_ROWS, 32'h0100);
		wr(`TIR_ADR_COLS, 32'h0300);
		wr(`TIR_ADR_SCALE, 32'h1f);
		wr(`TIR_ADR_PHASE, 32'h1be4);
		wr(`TIR_ADR_RATIO, {26'h0, ratio});
		wr(`TIR_ADR_CTRL, {24'h0, ctl});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 9; i++) rd(TA[i], TE[i]);
		rd(`TIR_ADR_STATUS, 32'h1324);
	endtask
	task automatic t_flag();
		cfg(8'h00, 6'h0d);
		rd(`TIR_ADR_STATUS, 32'hb4);
		wr(`TIR_ADR_RATIO, 32'h3f);
		rd(`TIR_ADR_STATUS, 32'h800000b4);
		wr(`TIR_ADR_RATIO, 32'h0d);
		rd(`TIR_ADR_STATUS, 32'hb4);
		wr(`TIR_ADR_COLS, 32'h3b00);
		rd(`TIR_ADR_STATUS, 32'hdc);
	endtask
	task automatic t_base();
		cfg(8'h01, 6'h0d);
		edge_wait();
		for (int i = 0; i < 4; i++) q(16'd243, 2'(i), 7'h0, 7'h0, 1'b1, 1'b0);
	endtask
	task automatic t_mirror();
		cfg(8'h39, 6'h00);
		edge_wait();
		for (int i = 0; i < 4; i++) q(16'd18, 2'(i), 7'h1, 7'h3, 1'b0, 1'b0);
	endtask
	task automatic t_alt();
		cfg(8'h03, 6'h0d);
		edge_wait();
		for (int i = 0; i < 4; i++) q(16'd243, 2'(i), 7'h0, 7'h0, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) q(16'd121, 2'(3 - i), 7'h0, 7'h0, 1'b1, 1'b1);
	endtask
	// two base subframes, the odd one shifted by a hop offset of two
	task automatic t_hop();
		cfg(8'h41, 6'h0d);
		wr(`TIR_ADR_SUBF, 32'h0102);
		wr(`TIR_ADR_PHASE, 32'h21be4);
		wr(`TIR_ADR_RATIO, 32'h0d);
		edge_wait();
		for (int i = 0; i < 4; i++) q(16'd243, 2'(i), 7'h0, 7'h0, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) q(16'd243, 2'(i + 2), 7'h0, 7'h0, 1'b1, 1'b0);
	endtask
	task automatic t_slave();
		int f0;
		cfg(8'h05, 6'h0d);
		f0 = fs_n;
		repeat (100) @(posedge clk);
		`CHK("idle", 0, fs_n - f0)
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		edge_wait();
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		for (int i = 0; i < 3; i++) q(16'd243, 2'(i), 7'h0, 7'h0, 1'b1, 1'b0);
		repeat (1500) @(posedge clk);
		`CHK("starts", 1, fs_n - f0)
		`CHK("stopped", 1'b0, mod)
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_flag();
		t_base();
		t_mirror();
		t_alt();
		t_hop();
		t_slave();
		results();
	end
endmodule
